// file: rtl/discharge_pin_pkg.sv
package discharge_pin_pkg;
    // Register byte addresses on the bus
    localparam logic [7:0] PIN_SETUP_ADDR = 8'h00;
    localparam logic [7:0] UNIT_SETUP_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;

    // Reset values and the unit setup writable mask
    localparam logic [7:0] PIN_SETUP_RESET = 8'h00;
    localparam logic [7:0] UNIT_SETUP_RESET = 8'h05;
    localparam logic [7:0] UNIT_SETUP_WRITABLE = 8'h1F;

    // Pin setup layout
    localparam int ROLE_LSB = 0;
    localparam int OPT_LSB = 2;

    // Option bits for the output roles
    localparam int OPT_POLARITY = 5;
    localparam int OPT_SUPPLY = 3;
    localparam int OPT_PULL_UP = 2;
    localparam int OPT_DRIVE_HIGH = 1;
    localparam int OPT_PULL_DOWN = 0;

    // Option fields for the analog role
    localparam int OPT_PULLUP_LSB = 4;
    localparam int OPT_POLY_LSB = 2;
    localparam int OPT_MEAS_LSB = 0;

    // Measurement unit setup layout
    localparam int CURRENT_UNIT_LSB = 0;
    localparam int VOLT_UNIT_BIT = 2;
    localparam int TEMP_EN_BIT = 3;
    localparam int TEMP_FET_BIT = 4;

    // Reported unit sizes
    localparam logic [13:0] VOLT_LSB_FINE_UV = 14'h03E8;
    localparam logic [13:0] VOLT_LSB_COARSE_UV = 14'h2710;
    localparam logic [9:0] CURRENT_LSB_0 = 10'h001;
    localparam logic [9:0] CURRENT_LSB_1 = 10'h00A;
    localparam logic [9:0] CURRENT_LSB_2 = 10'h064;
    localparam logic [9:0] CURRENT_LSB_3 = 10'h3E8;

    typedef enum logic [1:0] {
        ROLE_UNUSED = 2'b00,
        ROLE_GENERAL_OUTPUT = 2'b01,
        ROLE_DISCHARGE_DRIVER = 2'b10,
        ROLE_ANALOG_INPUT = 2'b11
    } role_type;

    typedef enum logic [1:0] {
        PULLUP_18K = 2'b00,
        PULLUP_180K = 2'b01,
        PULLUP_NONE = 2'b10,
        PULLUP_SPARE = 2'b11
    } pullup_type;

    typedef enum logic [1:0] {
        POLY_18K = 2'b00,
        POLY_180K = 2'b01,
        POLY_CUSTOM = 2'b10,
        POLY_RAW = 2'b11
    } poly_type;

    typedef enum logic [1:0] {
        MEAS_GENERAL_ADC = 2'b00,
        MEAS_CELL_TEMP = 2'b01,
        MEAS_REPORT_ONLY = 2'b10,
        MEAS_FET_TEMP = 2'b11
    } meas_type;
endpackage

// file: rtl/output_drive_decode.sv
module output_drive_decode (
    input wire logic [1:0] role_i,
    input wire logic [5:0] opt_i,
    input wire logic discharge_enable_i,
    input wire logic general_output_level_i,
    output logic level_o,
    output logic oe_o,
    output logic first_regulator_o,
    output logic pull_up_o,
    output logic pull_down_o
);
    wire is_gpo = (role_i == discharge_pin_pkg::ROLE_GENERAL_OUTPUT);
    wire is_driver = (role_i == discharge_pin_pkg::ROLE_DISCHARGE_DRIVER);
    wire active = is_gpo | is_driver;
    wire polarity = opt_i[discharge_pin_pkg::OPT_POLARITY];
    wire supply = opt_i[discharge_pin_pkg::OPT_SUPPLY];
    wire drive_high = opt_i[discharge_pin_pkg::OPT_DRIVE_HIGH];
    // Polarity only matters for the driver role
    wire driver_level = polarity ? discharge_enable_i : ~discharge_enable_i;
    wire want_high = is_gpo ? general_output_level_i : driver_level;
    // Float on high unless active drive or the first-regulator supply forces a push
    wire drives_now = active & (~want_high | drive_high | supply);

    assign oe_o = drives_now;
    assign level_o = drives_now & want_high;
    assign first_regulator_o = active & supply;
    // Pull-up combined with the first-regulator supply is left to software
    assign pull_up_o = active & opt_i[discharge_pin_pkg::OPT_PULL_UP];
    assign pull_down_o = active & opt_i[discharge_pin_pkg::OPT_PULL_DOWN];
endmodule

// file: rtl/analog_option_decode.sv
module analog_option_decode (
    input wire logic [1:0] role_i,
    input wire logic [5:0] opt_i,
    output logic active_o,
    output logic pullup_18k_o,
    output logic pullup_180k_o,
    output logic [1:0] poly_o,
    output logic [1:0] meas_o,
    output logic raw_counts_o,
    output logic cell_temp_o,
    output logic fet_temp_o
);
    wire is_analog = (role_i == discharge_pin_pkg::ROLE_ANALOG_INPUT);
    wire [1:0] pullup_code = opt_i[discharge_pin_pkg::OPT_PULLUP_LSB +: 2];
    wire [1:0] poly_code = opt_i[discharge_pin_pkg::OPT_POLY_LSB +: 2];
    wire [1:0] meas_code = opt_i[discharge_pin_pkg::OPT_MEAS_LSB +: 2];

    assign active_o = is_analog;
    assign pullup_18k_o = is_analog & (pullup_code == discharge_pin_pkg::PULLUP_18K);
    // Spare pull-up code is treated as no pull-up
    assign pullup_180k_o = is_analog & (pullup_code == discharge_pin_pkg::PULLUP_180K);
    assign poly_o = is_analog ? poly_code : 2'h0;
    assign raw_counts_o = is_analog & (poly_code == discharge_pin_pkg::POLY_RAW);
    assign meas_o = is_analog ? meas_code : 2'h0;
    assign cell_temp_o = is_analog & (meas_code == discharge_pin_pkg::MEAS_CELL_TEMP);
    assign fet_temp_o = is_analog & (meas_code == discharge_pin_pkg::MEAS_FET_TEMP);
endmodule

// file: rtl/discharge_driver_pin_config.sv
// Behaviour
// - Two role bits pick unused, general output, discharge driver or analog input.
// - Six option bits are decoded according to the selected role.
// - Driver role: polarity bit sets idle level; general output ignores it.
// - Output roles: supply bit picks 1.8 V regulator or first regulator output.
// - Output roles: pull-up bit enables weak pull-up to first regulator output.
// - Output roles: drive bit chooses float or active drive for high level; with the supply bit set, high is always driven.
// - Output roles: pull-down bit enables weak pull-down to ground.
// - Analog role: pull-up code 00 selects the 18 kOhm thermistor pull-up.
// - Analog role: code 01 selects 180 kOhm pull-up, code 10 none.
// - Analog role: polynomial code selects 18K, 180K, custom or raw counts.
// - Analog role: measurement type is general ADC, cell, report-only or FET temperature.
// - Internal temperature serves as FET temperature only when both enables are set.
// - Voltage unit bit selects 1 mV or 10 mV reported voltage units.
// - Current unit field selects 0.1, 1, 10 or 100 mA units.
module discharge_driver_pin_config (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic discharge_enable_i,
    input wire logic general_output_level_i,
    output logic pin_out_o,
    output logic pin_oe_o,
    output logic drive_from_first_regulator_o,
    output logic weak_pull_up_o,
    output logic weak_pull_down_o,
    output logic analog_input_active_o,
    output logic therm_pullup_18k_o,
    output logic therm_pullup_180k_o,
    output logic [1:0] poly_select_o,
    output logic [1:0] meas_type_o,
    output logic report_raw_counts_o,
    output logic cell_temp_protect_o,
    output logic fet_temp_protect_o,
    output logic internal_temp_as_cell_o,
    output logic internal_temp_as_fet_temp_o,
    output logic voltage_unit_select_o,
    output logic [13:0] voltage_lsb_uv_o,
    output logic [1:0] current_unit_o,
    output logic [9:0] current_lsb_tenth_ma_o
);
    logic [7:0] pin_setup_q;
    logic [7:0] pin_setup_d;
    logic [7:0] unit_setup_q;
    logic [7:0] unit_setup_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic pin_out_q;
    logic pin_oe_q;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i;
    wire commit = req & ack_q & wb_we_i & wb_sel_i[0];
    wire hit_pin = (wb_adr_i == discharge_pin_pkg::PIN_SETUP_ADDR);
    wire hit_unit = (wb_adr_i == discharge_pin_pkg::UNIT_SETUP_ADDR);
    wire hit_status = (wb_adr_i == discharge_pin_pkg::STATUS_ADDR);

    wire [1:0] role = pin_setup_q[discharge_pin_pkg::ROLE_LSB +: 2];
    wire [5:0] opt = pin_setup_q[discharge_pin_pkg::OPT_LSB +: 6];
    wire out_role = (role == discharge_pin_pkg::ROLE_GENERAL_OUTPUT) ||
                    (role == discharge_pin_pkg::ROLE_DISCHARGE_DRIVER);

    wire drv_level;
    wire drv_oe;

    // Both decoders see the same option bits; each one qualifies by role
    output_drive_decode u_drive (
        .role_i(role),
        .opt_i(opt),
        .discharge_enable_i(discharge_enable_i),
        .general_output_level_i(general_output_level_i),
        .level_o(drv_level),
        .oe_o(drv_oe),
        .first_regulator_o(drive_from_first_regulator_o),
        .pull_up_o(weak_pull_up_o),
        .pull_down_o(weak_pull_down_o)
    );

    analog_option_decode u_analog (
        .role_i(role),
        .opt_i(opt),
        .active_o(analog_input_active_o),
        .pullup_18k_o(therm_pullup_18k_o),
        .pullup_180k_o(therm_pullup_180k_o),
        .poly_o(poly_select_o),
        .meas_o(meas_type_o),
        .raw_counts_o(report_raw_counts_o),
        .cell_temp_o(cell_temp_protect_o),
        .fet_temp_o(fet_temp_protect_o)
    );

    // Measurement unit decode
    wire temp_en = unit_setup_q[discharge_pin_pkg::TEMP_EN_BIT];
    wire temp_fet = unit_setup_q[discharge_pin_pkg::TEMP_FET_BIT];
    wire [1:0] cur_unit = unit_setup_q[discharge_pin_pkg::CURRENT_UNIT_LSB +: 2];

    // FET-use bit is meaningless without the enable
    assign internal_temp_as_fet_temp_o = temp_en & temp_fet;
    // Internal source used as FET temperature is kept out of the cell figures
    assign internal_temp_as_cell_o = temp_en & ~temp_fet;
    assign voltage_unit_select_o = unit_setup_q[discharge_pin_pkg::VOLT_UNIT_BIT];
    assign voltage_lsb_uv_o = voltage_unit_select_o ? discharge_pin_pkg::VOLT_LSB_COARSE_UV :
                              discharge_pin_pkg::VOLT_LSB_FINE_UV;
    assign current_unit_o = cur_unit;
    assign current_lsb_tenth_ma_o = (cur_unit == 2'h0) ? discharge_pin_pkg::CURRENT_LSB_0 :
                                    (cur_unit == 2'h1) ? discharge_pin_pkg::CURRENT_LSB_1 :
                                    (cur_unit == 2'h2) ? discharge_pin_pkg::CURRENT_LSB_2 :
                                    discharge_pin_pkg::CURRENT_LSB_3;

    // Register next values; reserved top bits of the unit byte stay zero
    assign pin_setup_d = (commit && hit_pin) ? wb_dat_i[7:0] : pin_setup_q;
    assign unit_setup_d = (commit && hit_unit) ?
                          (wb_dat_i[7:0] & discharge_pin_pkg::UNIT_SETUP_WRITABLE) : unit_setup_q;

    wire [7:0] status_word = {2'h0, internal_temp_as_fet_temp_o, fet_temp_protect_o,
                              cell_temp_protect_o, analog_input_active_o, pin_oe_q, pin_out_q};
    // Unmapped addresses read as zero and ignore writes
    wire [7:0] read_byte = hit_pin ? pin_setup_q :
                           hit_unit ? unit_setup_q :
                           hit_status ? status_word : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_setup_q <= discharge_pin_pkg::PIN_SETUP_RESET;
            unit_setup_q <= discharge_pin_pkg::UNIT_SETUP_RESET;
        end else begin
            pin_setup_q <= pin_setup_d;
            unit_setup_q <= unit_setup_d;
        end
    end

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                rdata_q <= {24'h00_0000, read_byte};
            end
        end
    end

    // Pin drive is registered so the pad sees no decode glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_out_q <= drv_level;
            pin_oe_q <= drv_oe;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign pin_out_o = pin_out_q;
    assign pin_oe_o = pin_oe_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_unused_quiet;
        (role == discharge_pin_pkg::ROLE_UNUSED) && ($past(role) == discharge_pin_pkg::ROLE_UNUSED)
            |-> !pin_oe_o && !pin_out_o && !weak_pull_up_o && !weak_pull_down_o && !analog_input_active_o;
    endproperty
    a_unused_quiet: assert property (p_unused_quiet) else $error("unused role drives pin");

    property p_role_write;
        commit && hit_pin |=> role == $past(wb_dat_i[1:0]) && opt == $past(wb_dat_i[7:2]);
    endproperty
    a_role_write: assert property (p_role_write) else $error("pin setup write lost");

    property p_driver_idle;
        (role == discharge_pin_pkg::ROLE_DISCHARGE_DRIVER) && opt[discharge_pin_pkg::OPT_DRIVE_HIGH] &&
        !discharge_enable_i |=> pin_oe_o && (pin_out_o == !$past(opt[discharge_pin_pkg::OPT_POLARITY]));
    endproperty
    a_driver_idle: assert property (p_driver_idle) else $error("driver idle level wrong");

    property p_gpo_level;
        (role == discharge_pin_pkg::ROLE_GENERAL_OUTPUT) && opt[discharge_pin_pkg::OPT_DRIVE_HIGH]
            |=> pin_oe_o && (pin_out_o == $past(general_output_level_i));
    endproperty
    a_gpo_level: assert property (p_gpo_level) else $error("general output level wrong");

    property p_float_high;
        (role == discharge_pin_pkg::ROLE_GENERAL_OUTPUT) && general_output_level_i &&
        !opt[discharge_pin_pkg::OPT_DRIVE_HIGH] && !opt[discharge_pin_pkg::OPT_SUPPLY]
            |=> !pin_oe_o && !pin_out_o;
    endproperty
    a_float_high: assert property (p_float_high) else $error("high level not floated");

    property p_low_driven;
        out_role && !((role == discharge_pin_pkg::ROLE_GENERAL_OUTPUT) ? general_output_level_i :
                      (opt[discharge_pin_pkg::OPT_POLARITY] ? discharge_enable_i : !discharge_enable_i))
            |=> pin_oe_o && !pin_out_o;
    endproperty
    a_low_driven: assert property (p_low_driven) else $error("low level not driven");

    property p_output_options;
        out_role |-> drive_from_first_regulator_o == opt[discharge_pin_pkg::OPT_SUPPLY] &&
                     weak_pull_up_o == opt[discharge_pin_pkg::OPT_PULL_UP] &&
                     weak_pull_down_o == opt[discharge_pin_pkg::OPT_PULL_DOWN];
    endproperty
    a_output_options: assert property (p_output_options) else $error("output options wrong");

    property p_pullup_18k;
        (role == discharge_pin_pkg::ROLE_ANALOG_INPUT) && (opt[5:4] == 2'h0) |-> therm_pullup_18k_o && !therm_pullup_180k_o;
    endproperty
    a_pullup_18k: assert property (p_pullup_18k) else $error("18k pull-up not selected");

    property p_pullup_other;
        (role == discharge_pin_pkg::ROLE_ANALOG_INPUT) && opt[5] |-> !therm_pullup_18k_o && !therm_pullup_180k_o;
    endproperty
    a_pullup_other: assert property (p_pullup_other) else $error("pull-up on for no-pull-up code");

    property p_poly_meas;
        (role == discharge_pin_pkg::ROLE_ANALOG_INPUT) |-> poly_select_o == opt[3:2] &&
            report_raw_counts_o == (opt[3:2] == 2'h3) && fet_temp_protect_o == (opt[1:0] == 2'h3) &&
            cell_temp_protect_o == (opt[1:0] == 2'h1) && !drive_from_first_regulator_o;
    endproperty
    a_poly_meas: assert property (p_poly_meas) else $error("analog option decode wrong");

    property p_internal_fet;
        internal_temp_as_fet_temp_o == (unit_setup_q[discharge_pin_pkg::TEMP_EN_BIT] &&
                                        unit_setup_q[discharge_pin_pkg::TEMP_FET_BIT]);
    endproperty
    a_internal_fet: assert property (p_internal_fet) else $error("FET-use bit honoured without enable");

    property p_units;
        (voltage_lsb_uv_o == (voltage_unit_select_o ? 14'h2710 : 14'h03E8)) &&
        ((current_unit_o != 2'h3) || (current_lsb_tenth_ma_o == 10'h3E8));
    endproperty
    a_units: assert property (p_units) else $error("unit scaling wrong");

    property p_ack_shape;
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_shape: assert property (p_ack_shape) else $error("ack timing wrong");

    // Driver role with the discharge path enabled: pin level equals the polarity bit
    property p_driver_active;
        (role == discharge_pin_pkg::ROLE_DISCHARGE_DRIVER) && opt[discharge_pin_pkg::OPT_DRIVE_HIGH] &&
        discharge_enable_i |=> pin_oe_o && (pin_out_o == $past(opt[discharge_pin_pkg::OPT_POLARITY]));
    endproperty
    a_driver_active: assert property (p_driver_active) else $error("driver active level wrong");

    // Floating is not offered on the first-regulator supply
    property p_supply_push;
        out_role && opt[discharge_pin_pkg::OPT_SUPPLY] |=> pin_oe_o;
    endproperty
    a_supply_push: assert property (p_supply_push) else $error("pin floated on first regulator");

    property p_pullup_180k;
        (role == discharge_pin_pkg::ROLE_ANALOG_INPUT) && (opt[5:4] == 2'h1) |->
            therm_pullup_180k_o && !therm_pullup_18k_o;
    endproperty
    a_pullup_180k: assert property (p_pullup_180k) else $error("180k pull-up not selected");

    property p_analog_quiet;
        (role == discharge_pin_pkg::ROLE_ANALOG_INPUT) |=> !pin_oe_o && !weak_pull_up_o && !weak_pull_down_o;
    endproperty
    a_analog_quiet: assert property (p_analog_quiet) else $error("analog role drives pin");

    property p_non_analog_zero;
        (role != discharge_pin_pkg::ROLE_ANALOG_INPUT) |-> !analog_input_active_o && !therm_pullup_18k_o &&
            !therm_pullup_180k_o && (poly_select_o == 2'h0) && (meas_type_o == 2'h0) &&
            !report_raw_counts_o && !cell_temp_protect_o && !fet_temp_protect_o;
    endproperty
    a_non_analog_zero: assert property (p_non_analog_zero) else $error("analog decode outside role");

    // Reserved unit bits must never be stored
    property p_unit_write;
        commit && hit_unit |=> unit_setup_q == ($past(wb_dat_i[7:0]) & discharge_pin_pkg::UNIT_SETUP_WRITABLE);
    endproperty
    a_unit_write: assert property (p_unit_write) else $error("unit setup write wrong");

    property p_read_pin;
        req && !wb_ack_o && hit_pin |=> wb_dat_o == {24'h00_0000, $past(pin_setup_q)};
    endproperty
    a_read_pin: assert property (p_read_pin) else $error("pin setup read wrong");

    // Status is read-only; a write there must leave both settings alone
    property p_status_ro;
        commit && hit_status |=> $stable(pin_setup_q) && $stable(unit_setup_q);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed a setting");

    c_driver_toggle: cover property ((role == discharge_pin_pkg::ROLE_DISCHARGE_DRIVER) && $rose(discharge_enable_i));
    c_fet_source: cover property (fet_temp_protect_o);
    c_float: cover property (out_role && !pin_oe_o && drv_level == 1'b0 && general_output_level_i);
    c_write: cover property (commit && hit_unit);
    c_raw_cell: cover property (report_raw_counts_o && cell_temp_protect_o);
endmodule

// file: tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic discharge_enable_i;
    logic general_output_level_i;
    logic pin_out_o;
    logic pin_oe_o;
    logic drive_from_first_regulator_o;
    logic weak_pull_up_o;
    logic weak_pull_down_o;
    logic analog_input_active_o;
    logic therm_pullup_18k_o;
    logic therm_pullup_180k_o;
    logic [1:0] poly_select_o;
    logic [1:0] meas_type_o;
    logic report_raw_counts_o;
    logic cell_temp_protect_o;
    logic fet_temp_protect_o;
    logic internal_temp_as_cell_o;
    logic internal_temp_as_fet_temp_o;
    logic voltage_unit_select_o;
    logic [13:0] voltage_lsb_uv_o;
    logic [1:0] current_unit_o;
    logic [9:0] current_lsb_tenth_ma_o;
    int err_total;
    int tests_run;
    localparam logic [9:0] CUR_LSB [4] = '{10'h001, 10'h00A, 10'h064, 10'h3E8};

    discharge_driver_pin_config i_discharge_driver_pin_config (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .discharge_enable_i(discharge_enable_i), .general_output_level_i(general_output_level_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .drive_from_first_regulator_o(drive_from_first_regulator_o),
        .weak_pull_up_o(weak_pull_up_o), .weak_pull_down_o(weak_pull_down_o),
        .analog_input_active_o(analog_input_active_o), .therm_pullup_18k_o(therm_pullup_18k_o),
        .therm_pullup_180k_o(therm_pullup_180k_o), .poly_select_o(poly_select_o), .meas_type_o(meas_type_o),
        .report_raw_counts_o(report_raw_counts_o), .cell_temp_protect_o(cell_temp_protect_o),
        .fet_temp_protect_o(fet_temp_protect_o), .internal_temp_as_cell_o(internal_temp_as_cell_o),
        .internal_temp_as_fet_temp_o(internal_temp_as_fet_temp_o), .voltage_unit_select_o(voltage_unit_select_o),
        .voltage_lsb_uv_o(voltage_lsb_uv_o), .current_unit_o(current_unit_o),
        .current_lsb_tenth_ma_o(current_lsb_tenth_ma_o)
    );

    task automatic end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until the ack edge; data taken at that edge only
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                            input logic [31:0] wdat, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wdat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            end_sim();
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] dummy;
        wb_cycle(1'b1, adr, 4'h1, {24'h00_0000, dat}, dummy);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] got;
        wb_cycle(1'b0, adr, 4'hF, 32'h0000_0000, got);
        check(got, {24'h00_0000, exp});
    endtask

    // Pin flop samples inputs one edge after they are driven, so two edges pass before looking
    task automatic set_inputs(input logic en, input logic lvl);
        @(posedge clk_i);
        discharge_enable_i <= en;
        general_output_level_i <= lvl;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        logic [5:0] o;
        logic [4:0] v;
        logic wh;
        logic oe_e;
        err_total = 0;
        tests_run = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        discharge_enable_i = 1'b0;
        general_output_level_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(pin_oe_o, 1'b0);
        check(voltage_lsb_uv_o, 14'h2710);
        check(current_lsb_tenth_ma_o, 10'h00A);
        rd(discharge_pin_pkg::PIN_SETUP_ADDR, 8'h00);
        rd(discharge_pin_pkg::UNIT_SETUP_ADDR, 8'h05);
        // Every option set in the unused role must still leave the pin quiet
        wr(discharge_pin_pkg::PIN_SETUP_ADDR, 8'hFC);
        for (int k = 0; k < 4; k++) begin
            set_inputs(k[0], k[1]);
            check(pin_oe_o, 1'b0);
            check({drive_from_first_regulator_o, weak_pull_up_o, weak_pull_down_o, analog_input_active_o}, 4'h0);
        end
        for (int r = 1; r < 3; r++) begin
            for (int i = 0; i < 64; i++) begin
                o = i[5:0];
                wr(discharge_pin_pkg::PIN_SETUP_ADDR, {o, r[1:0]});
                for (int k = 0; k < 4; k++) begin
                    set_inputs(k[0], k[1]);
                    wh = (r == 1) ? k[1] : (o[5] ? k[0] : ~k[0]);
                    oe_e = ~wh | o[1] | o[3];
                    check(pin_oe_o, oe_e);
                    check(pin_out_o, oe_e & wh);
                    check(drive_from_first_regulator_o, o[3]);
                    check(weak_pull_up_o, o[2]);
                    check(weak_pull_down_o, o[0]);
                    check({analog_input_active_o, poly_select_o, meas_type_o}, 5'h00);
                end
            end
        end
        for (int i = 0; i < 64; i++) begin
            o = i[5:0];
            wr(discharge_pin_pkg::PIN_SETUP_ADDR, {o, 2'b11});
            #1;
            check(analog_input_active_o, 1'b1);
            check(therm_pullup_18k_o, o[5:4] == 2'b00);
            check(therm_pullup_180k_o, o[5:4] == 2'b01);
            check(poly_select_o, o[3:2]);
            check(report_raw_counts_o, o[3:2] == 2'b11);
            check(meas_type_o, o[1:0]);
            check(cell_temp_protect_o, o[1:0] == 2'b01);
            check(fet_temp_protect_o, o[1:0] == 2'b11);
            check({pin_oe_o, weak_pull_up_o, weak_pull_down_o}, 3'h0);
        end
        // Reserved top bits written as ones to prove they read back zero
        for (int i = 0; i < 32; i++) begin
            v = i[4:0];
            wr(discharge_pin_pkg::UNIT_SETUP_ADDR, {3'b111, v});
            #1;
            check(internal_temp_as_fet_temp_o, v[3] & v[4]);
            check(internal_temp_as_cell_o, v[3] & ~v[4]);
            check(voltage_unit_select_o, v[2]);
            check(voltage_lsb_uv_o, v[2] ? 14'h2710 : 14'h03E8);
            check(current_unit_o, v[1:0]);
            check(current_lsb_tenth_ma_o, CUR_LSB[v[1:0]]);
            rd(discharge_pin_pkg::UNIT_SETUP_ADDR, {3'b000, v});
        end
        wr(discharge_pin_pkg::PIN_SETUP_ADDR, 8'h0F);
        rd(discharge_pin_pkg::STATUS_ADDR, 8'h34);
        wr(discharge_pin_pkg::STATUS_ADDR, 8'hFF);
        rd(discharge_pin_pkg::STATUS_ADDR, 8'h34);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h00);
        rd(discharge_pin_pkg::PIN_SETUP_ADDR, 8'h0F);
        begin
            logic [31:0] dummy;
            wb_cycle(1'b1, discharge_pin_pkg::PIN_SETUP_ADDR, 4'h0, 32'h0000_00FE, dummy);
        end
        rd(discharge_pin_pkg::PIN_SETUP_ADDR, 8'h0F);
        end_sim();
    end
endmodule
